// ---- common/adc_scan_params.svh ----
// Constants for the converter scan control: idle values, widths, timing
`ifndef ADC_SCAN_PARAMS_SVH
`define ADC_SCAN_PARAMS_SVH
`define DAC_W 10
`define MUX_W 8
`define NEG_W 3
`define DAC_MID 10'h200
`define MUX_IDLE 8'h01
`define NEG_IDLE 3'h0
`define ENABLE_WAIT_NS 200
`define CLK_PERIOD_NS 8
`define ENABLE_WAIT_CYC ((`ENABLE_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DUMMY_CMPS 10
`define APB_CTRL 12'h000
`define APB_DAC 12'h004
`define APB_MUX 12'h008
`define APB_STAT 12'h00C
`define APB_LIMLO 12'h010
`define APB_LIMHI 12'h014
`define APB_CMD 12'h018
`define CTRL_CONV_ON 0
`define CTRL_AMP_ON 1
`define CTRL_GND 2
`define CTRL_SUPREF 3
`define CTRL_IREF 4
`define CTRL_PASS 5
`define CTRL_SCT 6
`define CTRL_SETTLE 7
`define CTRL_NEG_LSB 8
`define CTRL_RESET 32'h0000_0020
`endif

// ---- common/adc_scan_pkg.sv ----
// Types shared by the converter scan control ends
package adc_scan_pkg;
  typedef enum logic [6:0] {
    CS_IDLE = 7'b000_0001,
    CS_WAIT = 7'b000_0010,
    CS_SAMPLE = 7'b000_0100,
    CS_HOLD = 7'b000_1000,
    CS_CMP_LATCH_PRECHARGE_N = 7'b001_0000,
    CS_CAPTURE = 7'b010_0000,
    CS_DONE = 7'b100_0000
  } ctl_state_e;
  typedef logic [9:0] dac_code_t;
endpackage : adc_scan_pkg

// ---- common/adc_scan_if.sv ----
// Scan-cell level link between the test controller and the converter core
`timescale 1ns/1ns
interface adc_scan_if;
  logic sample_hold;
  logic cmp_latch_precharge_n;
  logic [7:0] pos_channel_select;
  logic [2:0] neg_input_select;
  logic neg_input_ground_en;
  logic supply_ref_select;
  logic internal_ref_to_dac_en;
  logic amp_passgate_en;
  logic switchcap_test_route;
  logic amp_settle_assist;
  logic amp_power_on;
  logic converter_power_on;
  logic [9:0] dac_code;
  logic capture;
  logic cmp_out;
  modport ctrl (output sample_hold, cmp_latch_precharge_n, pos_channel_select, neg_input_select,
    neg_input_ground_en, supply_ref_select, internal_ref_to_dac_en, amp_passgate_en,
    switchcap_test_route, amp_settle_assist, amp_power_on, converter_power_on, dac_code, capture,
    input cmp_out);
  modport core (input sample_hold, cmp_latch_precharge_n, pos_channel_select, neg_input_select,
    neg_input_ground_en, supply_ref_select, internal_ref_to_dac_en, amp_passgate_en,
    switchcap_test_route, amp_settle_assist, amp_power_on, converter_power_on, dac_code, capture,
    output cmp_out);
endinterface : adc_scan_if

// ---- hdl/sar_search.sv ----
// Digital successive-approximation search around the comparator
`timescale 1ns/1ns
`include "adc_scan_params.svh"
module sar_search (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic cmp,
  output adc_scan_pkg::dac_code_t trial,
  output logic busy,
  output adc_scan_pkg::dac_code_t result
);
  adc_scan_pkg::dac_code_t bit_q;
  adc_scan_pkg::dac_code_t trial_q;
  adc_scan_pkg::dac_code_t result_q;
  logic busy_q;

  // One comparison per clock, msb first; ten comparisons in all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q <= 10'h000;
      trial_q <= `DAC_MID;
      busy_q <= 1'b0;
    end else if (start && !busy_q) begin
      bit_q <= `DAC_MID;
      trial_q <= `DAC_MID;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      // High comparator means input above trial, so keep the bit
      trial_q <= (cmp ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
      bit_q <= bit_q >> 1;
      if (bit_q == 10'h001) begin
        busy_q <= 1'b0;
        trial_q <= `DAC_MID;
      end
    end
  end

  // Result latched on the last comparison
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 10'h000;
    end else if (busy_q && bit_q == 10'h001) begin
      result_q <= cmp ? trial_q : (trial_q & ~bit_q);
    end
  end

  assign trial = trial_q;
  assign busy = busy_q;
  assign result = result_q;
endmodule : sar_search

// ---- hdl/adc_core_end.sv ----
// Converter core end: decodes scan cells into analog controls, runs dummy conversion
`timescale 1ns/1ns
`include "adc_scan_params.svh"
module adc_core_end (
  input wire logic pclk,
  input wire logic presetn,
  adc_scan_if.core scan,
  input wire logic cmp_raw,
  output logic track_en,
  output logic latch_precharge,
  output logic [7:0] pos_mux_en,
  output logic [2:0] neg_mux_sel,
  output logic neg_gnd,
  output logic ref_is_supply,
  output logic ref_is_bandgap,
  output logic passgate_closed,
  output logic amp_to_ch4_pin,
  output logic core_powered,
  output adc_scan_pkg::dac_code_t dac_drive,
  output logic dummy_busy
);
  logic c1_q, c2_q, c3_q, cmp_q, cmp_cell_q, conv_on_q, start_q;
  logic busy;
  adc_scan_pkg::dac_code_t trial;

  // Comparator is asynchronous to pclk: three stages, change taken when last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= 1'b0;
      c2_q <= 1'b0;
      c3_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      c1_q <= cmp_raw;
      c2_q <= c1_q;
      c3_q <= c2_q;
      if (c2_q == c3_q) cmp_q <= c3_q;
    end
  end

  // Capture phase loads the comparator scan cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmp_cell_q <= 1'b0;
    else if (scan.capture) cmp_cell_q <= cmp_q;
  end
  assign scan.cmp_out = cmp_cell_q;

  // Rising power-on starts the dummy conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_on_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      conv_on_q <= scan.converter_power_on;
      start_q <= scan.converter_power_on && !conv_on_q;
    end
  end

  sar_search sar_search_inst (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_q),
    .cmp(cmp_q),
    .trial(trial),
    .busy(busy),
    .result()
  );

  // Analog switch decode; dummy conversion owns the DAC while it runs
  assign track_en = !scan.sample_hold;
  assign latch_precharge = !scan.cmp_latch_precharge_n;
  assign amp_to_ch4_pin = scan.switchcap_test_route;
  assign ref_is_supply = scan.supply_ref_select;
  assign ref_is_bandgap = scan.internal_ref_to_dac_en;
  assign neg_mux_sel = scan.neg_input_select;
  assign passgate_closed = scan.amp_passgate_en;
  assign core_powered = scan.converter_power_on;
  assign neg_gnd = scan.neg_input_ground_en;
  assign pos_mux_en = scan.pos_channel_select;
  assign dac_drive = busy ? trial : scan.dac_code;
  assign dummy_busy = busy;
endmodule : adc_core_end

// ---- hdl/scan_test_ctrl.sv ----
// Test controller end: APB registers and the two-point limit check sequence
// Operation
// - Hold low tracks, high freezes sample
// - Hold asserted only while amp clock high
// - Precharge low charges comparator latch
// - Switch-cap test routes amp to ch4
// - Settle assist high two amp clocks
// - Supply select makes Vcc the reference
// - Internal enable puts bandgap on DAC
// - Three bits choose negative input
// - Pass-gate enable closes amplifier gate
// - Idle values drive converter unused
// - Exactly one negative source selected
// - Avoid differential amplifier through scan
// - Lower code expects low, upper high
// - Channel pin input, pull-up off
// - Enable triggers ten-comparison dummy conversion
// - Wait 200 ns after enable
// - DAC at midpoint while sampling
// - Search done in digital logic
// - Power-on input powers converter core
// - Ground enable grounds negative input
// - Ten-bit DAC, bit 9 most significant
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ns
`include "adc_scan_params.svh"
module scan_test_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pin_is_input,
  output logic pin_pullup_en,
  adc_scan_if.ctrl scan
);
  adc_scan_pkg::ctl_state_e st_q;
  logic [31:0] ctrl_q;
  adc_scan_pkg::dac_code_t dac_q, lim_lo_q, lim_hi_q;
  logic [7:0] mux_q;
  logic upper_q, lo_ok_q, hi_ok_q, done_q, pass_q, err_q, sel_bad;
  logic [7:0] wait_q;
  logic wr, rd, go;

  // True when more than one negative source is on: ground enabled with a non-zero pin select
  function automatic logic neg_conflict(input logic [2:0] sel, input logic gnd);
    neg_conflict = (sel != 3'h0) && gnd;
  endfunction : neg_conflict

  // One-hot check for the positive channel
  function automatic logic not_onehot(input logic [7:0] v);
    not_onehot = (v == 8'h00) || ((v & (v - 8'h01)) != 8'h00);
  endfunction : not_onehot

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign go = wr && paddr == `APB_CMD && pwdata[0];
  assign sel_bad = neg_conflict(ctrl_q[`CTRL_NEG_LSB +: 3], ctrl_q[`CTRL_GND]) || not_onehot(mux_q);
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Register writes; a write while a check runs is ignored for every register, limits included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      dac_q <= `DAC_MID;
      mux_q <= `MUX_IDLE;
      lim_lo_q <= 10'h000;
      lim_hi_q <= 10'h3FF;
    end else if (wr && st_q == adc_scan_pkg::CS_IDLE) begin
      case (paddr)
        `APB_CTRL: ctrl_q <= {21'h0, pwdata[10:0]};
        `APB_DAC: dac_q <= pwdata[9:0];
        `APB_MUX: mux_q <= pwdata[7:0];
        `APB_LIMLO: lim_lo_q <= pwdata[9:0];
        `APB_LIMHI: lim_hi_q <= pwdata[9:0];
        default: ;
      endcase
    end
  end

  // Read data registered at setup so it is a flop at the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        `APB_CTRL: prdata <= ctrl_q;
        `APB_DAC: prdata <= {22'h0, dac_q};
        `APB_MUX: prdata <= {24'h0, mux_q};
        `APB_STAT: prdata <= {26'h0, err_q, pass_q, hi_ok_q, lo_ok_q, done_q, st_q != adc_scan_pkg::CS_IDLE};
        `APB_LIMLO: prdata <= {22'h0, lim_lo_q};
        `APB_LIMHI: prdata <= {22'h0, lim_hi_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Check sequence: wait, sample, hold, apply limit, precharge, capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= adc_scan_pkg::CS_IDLE;
      wait_q <= 8'h00;
      upper_q <= 1'b0;
    end else begin
      case (st_q)
        adc_scan_pkg::CS_IDLE: begin
          upper_q <= 1'b0;
          wait_q <= 8'h00;
          if (go && !sel_bad) st_q <= adc_scan_pkg::CS_WAIT;
        end
        adc_scan_pkg::CS_WAIT: begin
          // Covers the 200 ns start-up and the dummy conversion that rides in it
          wait_q <= wait_q + 8'h01;
          if (wait_q >= 8'(`ENABLE_WAIT_CYC + `DUMMY_CMPS)) st_q <= adc_scan_pkg::CS_SAMPLE;
        end
        adc_scan_pkg::CS_SAMPLE: st_q <= adc_scan_pkg::CS_HOLD;
        adc_scan_pkg::CS_HOLD: st_q <= adc_scan_pkg::CS_CMP_LATCH_PRECHARGE_N;
        adc_scan_pkg::CS_CMP_LATCH_PRECHARGE_N: st_q <= adc_scan_pkg::CS_CAPTURE;
        adc_scan_pkg::CS_CAPTURE: begin
          upper_q <= 1'b1;
          st_q <= upper_q ? adc_scan_pkg::CS_DONE : adc_scan_pkg::CS_SAMPLE;
        end
        adc_scan_pkg::CS_DONE: st_q <= adc_scan_pkg::CS_IDLE;
        default: st_q <= adc_scan_pkg::CS_IDLE;
      endcase
    end
  end

  // Verdicts; a new start clears done, the cell read after each capture sets the limit verdicts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_ok_q <= 1'b0;
      hi_ok_q <= 1'b0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (go) begin
        done_q <= 1'b0;
        err_q <= sel_bad;
      end
      // The cell loads on the capture edge, so it is read one cycle later; reading it
      // on the capture edge itself would judge the previous vector's comparator
      if (st_q == adc_scan_pkg::CS_SAMPLE && upper_q) lo_ok_q <= !scan.cmp_out;
      if (st_q == adc_scan_pkg::CS_DONE) begin
        done_q <= 1'b1;
        hi_ok_q <= scan.cmp_out;
        pass_q <= lo_ok_q && scan.cmp_out;
      end
    end
  end

  // Scan cell drive; register values whenever no check runs, the sequence overrides the power-on, hold, precharge, capture and DAC lines
  always_comb begin
    scan.converter_power_on = ctrl_q[`CTRL_CONV_ON] || st_q != adc_scan_pkg::CS_IDLE;
    // Amplifier stays off: its switch-cap clock cannot be met here
    scan.amp_power_on = 1'b0;
    scan.amp_settle_assist = 1'b0;
    scan.switchcap_test_route = ctrl_q[`CTRL_SCT];
    scan.neg_input_ground_en = ctrl_q[`CTRL_GND];
    scan.supply_ref_select = ctrl_q[`CTRL_SUPREF];
    scan.internal_ref_to_dac_en = ctrl_q[`CTRL_IREF];
    scan.amp_passgate_en = ctrl_q[`CTRL_PASS];
    scan.neg_input_select = ctrl_q[`CTRL_NEG_LSB +: 3];
    scan.pos_channel_select = mux_q;
    scan.sample_hold = 1'b1;
    scan.cmp_latch_precharge_n = 1'b1;
    scan.dac_code = dac_q;
    scan.capture = 1'b0;
    case (st_q)
      adc_scan_pkg::CS_SAMPLE: begin
        scan.sample_hold = 1'b0;
        scan.dac_code = `DAC_MID;
      end
      adc_scan_pkg::CS_HOLD: scan.dac_code = upper_q ? lim_hi_q : lim_lo_q;
      adc_scan_pkg::CS_CMP_LATCH_PRECHARGE_N: begin
        scan.dac_code = upper_q ? lim_hi_q : lim_lo_q;
        scan.cmp_latch_precharge_n = 1'b0;
      end
      adc_scan_pkg::CS_CAPTURE: begin
        scan.dac_code = `DAC_MID;
        scan.capture = 1'b1;
      end
      adc_scan_pkg::CS_WAIT: scan.dac_code = `DAC_MID;
      default: ;
    endcase
  end

  // Channel pin under test is an input with pull-up off while the check runs
  assign pin_is_input = 1'b1;
  assign pin_pullup_en = 1'b0;
endmodule : scan_test_ctrl

// ---- verif/adc_scan_checker.sv ----
// Concurrent checks on the scan link between the controller and the converter core
`timescale 1ns/1ns
`include "adc_scan_params.svh"
module adc_scan_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_hold,
  input wire logic cmp_latch_precharge_n,
  input wire logic [7:0] pos_channel_select,
  input wire logic [2:0] neg_input_select,
  input wire logic neg_input_ground_en,
  input wire logic amp_power_on,
  input wire logic amp_settle_assist,
  input wire logic converter_power_on,
  input wire logic [9:0] dac_code,
  input wire logic capture
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] on_cnt_q;
  // Cycles with the converter powered; saturates so a long powered stretch cannot wrap to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_cnt_q <= 8'h00;
    else if (!converter_power_on) on_cnt_q <= 8'h00;
    else if (on_cnt_q != 8'hFF) on_cnt_q <= on_cnt_q + 8'h01;
  end
  AST_DAC_MID_SAMPLE: assert property (!sample_hold |-> dac_code == `DAC_MID)
    else $error("DAC code off midpoint while sampling");
  AST_SAMPLE_POWERED: assert property (!sample_hold |-> converter_power_on)
    else $error("Sampling with converter unpowered");
  AST_ENABLE_WAIT: assert property ($fell(sample_hold) |-> on_cnt_q >= `ENABLE_WAIT_CYC)
    else $error("Sampling began too soon after power-on");
  AST_AMP_UNUSED: assert property (!amp_power_on && !amp_settle_assist)
    else $error("Differential amplifier operated");
  AST_ONE_NEG_SOURCE: assert property (capture |-> !(neg_input_ground_en && neg_input_select != 3'h0))
    else $error("Two negative sources at capture");
  AST_ONE_CHANNEL: assert property (capture |-> $onehot(pos_channel_select))
    else $error("Channel select not one-hot at capture");
  AST_CAPTURE_PULSE: assert property (capture |=> !capture)
    else $error("Capture longer than one cycle");
  AST_CMP_LATCH_PRECHARGE_N_BEFORE_CAPTURE: assert property (capture |-> $past(cmp_latch_precharge_n) == 1'b0)
    else $error("Capture without precharge before it");
  AST_CMP_LATCH_PRECHARGE_N_IN_HOLD: assert property (!cmp_latch_precharge_n || capture |-> sample_hold)
    else $error("Precharge or capture while tracking");
endmodule : adc_scan_checker

// ---- verif/adc_boundary_scan_control_tb.sv ----
// Testbench joining the controller and converter core ends over the scan link
`timescale 1ns/1ns
`include "adc_scan_params.svh"
module adc_boundary_scan_control_tb;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, pin_is_input, pin_pullup_en, cmp_raw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic track_en, latch_precharge, neg_gnd, ref_is_supply, ref_is_bandgap, passgate_closed;
  logic amp_to_ch4_pin, core_powered, dummy_busy;
  logic [7:0] pos_mux_en;
  logic [2:0] neg_mux_sel;
  adc_scan_pkg::dac_code_t dac_drive;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, cap_n, trk_n, pre_n;
  logic [11:0] ra [7] = '{`APB_CTRL, `APB_DAC, `APB_MUX, `APB_STAT, `APB_LIMLO, `APB_LIMHI, 12'h01C};
  logic [31:0] re [7] = '{`CTRL_RESET, 32'h0000_0200, 32'h0000_0001, 0, 0, 32'h0000_03FF, 0};
  always #4 pclk = ~pclk;
  adc_scan_if sif ();
  scan_test_ctrl scan_test_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_is_input(pin_is_input), .pin_pullup_en(pin_pullup_en), .scan(sif.ctrl));
  adc_core_end adc_core_end_inst (.pclk(pclk), .presetn(presetn), .scan(sif.core), .cmp_raw(cmp_raw),
    .track_en(track_en), .latch_precharge(latch_precharge), .pos_mux_en(pos_mux_en),
    .neg_mux_sel(neg_mux_sel), .neg_gnd(neg_gnd), .ref_is_supply(ref_is_supply),
    .ref_is_bandgap(ref_is_bandgap), .passgate_closed(passgate_closed), .amp_to_ch4_pin(amp_to_ch4_pin),
    .core_powered(core_powered), .dac_drive(dac_drive), .dummy_busy(dummy_busy));
  adc_scan_checker adc_scan_checker_inst (.pclk(pclk), .presetn(presetn), .sample_hold(sif.sample_hold),
    .cmp_latch_precharge_n(sif.cmp_latch_precharge_n), .pos_channel_select(sif.pos_channel_select),
    .neg_input_select(sif.neg_input_select), .neg_input_ground_en(sif.neg_input_ground_en),
    .amp_power_on(sif.amp_power_on), .amp_settle_assist(sif.amp_settle_assist),
    .converter_power_on(sif.converter_power_on), .dac_code(sif.dac_code), .capture(sif.capture));
  // Phase counters sampled mid-cycle, away from the edge that moves the sequencer
  always @(negedge pclk) begin
    if (sif.capture === 1'b1) cap_n++;
    if (track_en === 1'b1) trk_n++;
    if (latch_precharge === 1'b1) pre_n++;
  end
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      $display("MISMATCH timeout exp finished seen hung");
      close_out();
    end
  end
  task close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; the request stands until pready is seen high, then is released
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cmp_raw = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("idle_lines", {sif.sample_hold, sif.cmp_latch_precharge_n, sif.amp_passgate_en, sif.pos_channel_select,
      sif.dac_code}, {3'h7, `MUX_IDLE, `DAC_MID});
    chk("pins", {pin_is_input, pin_pullup_en, pslverr}, 3'h4);
    chk("track_cmp_latch_precharge_n", {track_en, latch_precharge}, 2'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 0, rd);
      chk("reg_reset", rd, re[i]);
    end
    $display("test reset done");
    apb(1'b1, `APB_CTRL, 32'h0000_005C, rd);
    chk("ctrl_a", {amp_to_ch4_pin, passgate_closed, ref_is_bandgap, ref_is_supply, neg_gnd}, 5'h17);
    apb(1'b1, `APB_CTRL, 32'h0000_0520, rd);
    chk("ctrl_b", {amp_to_ch4_pin, passgate_closed, ref_is_bandgap, ref_is_supply, neg_gnd, neg_mux_sel},
      {5'h08, 3'h5});
    apb(1'b1, `APB_DAC, 32'h0000_0155, rd);
    chk("dac", dac_drive, 10'h155);
    apb(1'b1, `APB_MUX, 32'h0000_0080, rd);
    chk("mux", pos_mux_en, 8'h80);
    $display("test pass-through done");
    apb(1'b1, `APB_CTRL, 32'h0000_0021, rd);
    chk("powered", core_powered, 1'b1);
    n = 0;
    while (dummy_busy !== 1'b1 && n < 10) begin
      @(posedge pclk);
      #1;
      n++;
    end
    n = 0;
    while (dummy_busy === 1'b1 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("dummy_len", n, `DUMMY_CMPS);
    $display("test dummy done");
    apb(1'b1, `APB_MUX, 32'h0000_0008, rd);
    apb(1'b1, `APB_LIMLO, 32'h0000_0123, rd);
    apb(1'b1, `APB_LIMHI, 32'h0000_0143, rd);
    // Steady comparator level per run, since the core synchroniser lags the capture
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      cmp_raw <= k[0];
      cap_n = 0;
      trk_n = 0;
      pre_n = 0;
      apb(1'b1, `APB_CMD, 32'h0000_0001, rd);
      apb(1'b0, `APB_STAT, 0, rd);
      chk("busy", rd[0], 1'b1);
      apb(1'b1, `APB_DAC, 32'h0000_03FF, rd);
      n = 0;
      do begin
        apb(1'b0, `APB_STAT, 0, rd);
        n++;
      end while (rd[1] !== 1'b1 && n < 40);
      chk("stat", rd, k ? 32'h0000_000A : 32'h0000_0006);
      chk("captures", cap_n, 2);
      chk("cmp_out", sif.cmp_out, k[0]);
      chk("phases", {trk_n != 0, pre_n != 0}, 2'h3);
      apb(1'b0, `APB_DAC, 0, rd);
      chk("dac_kept", rd, 32'h0000_0155);
      $display("test limit check %0d done", k);
    end
    cap_n = 0;
    apb(1'b1, `APB_MUX, 32'h0000_0003, rd);
    apb(1'b1, `APB_CMD, 32'h0000_0001, rd);
    repeat (40) @(posedge pclk);
    apb(1'b0, `APB_STAT, 0, rd);
    chk("sel_err", {rd[5], cap_n == 0}, 2'h3);
    $display("test bad select done");
    close_out();
  end
endmodule : adc_boundary_scan_control_tb
